// file: hdl/ucs_rate_div.sv
// divider for the fourth rate input, counts rising edges of its synchronised level
module ucs_rate_div
   import ucs_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic rate_lvl,
   output logic      div2,
   output logic      div4,
   output logic      div8
);
   import ucs_pkg::*;

   typedef struct packed {
      logic       prev;
      logic [2:0] cnt;
   } ucs_div_state_t;

   ucs_div_state_t st;
   ucs_div_state_t next_st;

   always_comb begin
      next_st      = st;
      next_st.prev = rate_lvl;
      if (rate_lvl && !st.prev) begin
         next_st.cnt = st.cnt + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // synchroniser resets high, so prev starts high: no false edge after reset
         st <= '{prev: 1'b1, cnt: DIV_RST};
      end else begin
         st <= next_st;
      end
   end

   // bit k of an edge counter toggles every 2^k input periods
   assign div2 = st.cnt[0];
   assign div4 = st.cnt[1];
   assign div8 = st.cnt[2];
endmodule

// file: hdl/ucs_regs.sv
// line format / clock control register and line and modem status register
module ucs_regs
   import ucs_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       bus_sel,
   input  wire logic       bus_rd,
   input  wire logic       bus_wr,
   input  wire logic       bus_addr,
   input  wire logic [7:0] bus_wdata,
   output logic      [7:0] bus_rdata,
   input  wire logic       terminal_ready_ctrl_bit,
   input  wire logic       rx_enable,
   input  wire logic       tx_enable,
   input  wire logic       rx_parity_check_bit,
   input  wire logic       escape_strip_bit,
   input  wire logic       tx_parity_gen_bit,
   input  wire logic       transparent_mode_bit,
   input  wire logic [7:0] escape_char,
   input  wire logic [7:0] sync_char,
   input  wire logic       tx_buf_load,
   input  wire logic       tx_buf_to_shift,
   input  wire logic       rx_char_done,
   input  wire logic [7:0] rx_char,
   input  wire logic       rx_stop_ok,
   input  wire logic       rx_buf_read,
   input  wire logic       cd_n,
   input  wire logic       dsr_n,
   input  wire logic       ri_n,
   input  wire logic       tx_1x_clk,
   input  wire logic       rx_1x_clk,
   input  wire logic       rate1_clk,
   input  wire logic       rate2_clk,
   input  wire logic       rate3_clk,
   input  wire logic       rate4_clk,
   output logic            terminal_ready_n,
   output logic      [3:0] char_bits,
   output logic            sync_mode,
   output logic            odd_parity,
   output logic            tx_parity_on,
   output logic            tx_clk_src,
   output logic            rx_clk_src,
   output logic            rx_buf_load,
   output logic            rx_char_drop,
   output logic            tx_buffer_empty_flag,
   output logic            rx_char_received_flag
);
   import ucs_pkg::*;

   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [7:0]       ctrl2;
      logic [7:0]       rdata;
      logic             tx_empty;
      logic             rx_full;
      logic             ovr;
      logic             b3;
      logic             b4;
      logic             dsc;
      logic             prev_esc;
      logic             sync_pend;
      logic             cd_q;
      logic             dsr_q;
      logic             ri_q;
      logic             dtr_n;
      logic             tx_clk;
      logic             rx_clk;
      logic             rx_load;
      logic             rx_drop;
   } ucs_state_t;

   ucs_state_t st;
   ucs_state_t next_st;

   logic       div2;
   logic       div4;
   logic       div8;
   logic [7:0] len_mask;
   logic [7:0] char_m;
   logic       esc_hit;
   logic       syn_hit;
   logic       strip_hit;
   logic       wr_ctrl;
   logic       rd_ctrl;
   logic       rd_stat;
   logic       modem_set;
   logic       parity_bad;
   logic [7:0] status_vec;
   ucs_csel_t  csel;

   ucs_rate_div u_div (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .rate_lvl (st.s2[PIN_RATE4]),
      .div2     (div2),
      .div4     (div4),
      .div8     (div8)
   );

   assign wr_ctrl = bus_sel && bus_wr && (bus_addr == ADDR_CTRL2);
   assign rd_ctrl = bus_sel && bus_rd && (bus_addr == ADDR_CTRL2);
   assign rd_stat = bus_sel && bus_rd && (bus_addr == ADDR_STATUS);
   assign csel    = ucs_csel_t'(st.ctrl2[CSEL_HI:CSEL_LO]);

   // characters shorter than 8 bits are right justified
   assign len_mask   = FULL_MASK >> st.ctrl2[CL_HI:CL_LO];
   assign char_m     = rx_char & len_mask;
   assign esc_hit    = sync_mode && escape_strip_bit && (char_m == (escape_char & len_mask));
   assign syn_hit    = char_m == (sync_char & len_mask);
   // with bit three set, non-transparent drops every sync; transparent drops sync only after escape
   assign strip_hit  = sync_mode && st.ctrl2[RXCLK_BIT] && syn_hit
                       && (!transparent_mode_bit || (escape_strip_bit && st.prev_esc));
   // even parity: xor of all bits is zero; odd: one
   assign parity_bad = (^char_m) ^ st.ctrl2[ODD_BIT];

   // modem pins are active low; CD/DSR changes count while terminal ready is on, only ring turn-on while it is off
   assign modem_set = terminal_ready_ctrl_bit
                      ? ((st.s2[PIN_CD] != st.cd_q) || (st.s2[PIN_DSR] != st.dsr_q))
                      : (st.ri_q && !st.s2[PIN_RI]);

   assign status_vec = {st.dsc, !st.s2[PIN_DSR], !st.s2[PIN_CD], st.b4, st.b3,
                        st.ovr, st.rx_full, st.tx_empty};

   always_comb begin
      next_st    = st;
      next_st.s1 = {rate4_clk, rate3_clk, rate2_clk, rate1_clk, rx_1x_clk, tx_1x_clk,
                    ri_n, dsr_n, cd_n};
      next_st.s2 = st.s1;
      next_st.cd_q  = st.s2[PIN_CD];
      next_st.dsr_q = st.s2[PIN_DSR];
      next_st.ri_q  = st.s2[PIN_RI];
      next_st.dtr_n = !terminal_ready_ctrl_bit;

      // software is expected to write this only while both sections are idle
      if (wr_ctrl) begin
         next_st.ctrl2 = bus_wdata;
      end
      if (rd_ctrl) begin
         next_st.rdata = st.ctrl2;
      end else if (rd_stat) begin
         next_st.rdata = status_vec;
      end

      // clock routing
      case (csel)
         CS_1X:       next_st.tx_clk = st.s2[PIN_TX1X];
         CS_RATE1:    next_st.tx_clk = st.s2[PIN_RATE1];
         CS_RATE2:    next_st.tx_clk = st.s2[PIN_RATE2];
         CS_RATE3:    next_st.tx_clk = st.s2[PIN_RATE3];
         CS_RATE4:    next_st.tx_clk = st.s2[PIN_RATE4];
         CS_RATE4_D2: next_st.tx_clk = div2;
         CS_RATE4_D4: next_st.tx_clk = div4;
         CS_RATE4_D8: next_st.tx_clk = div8;
         default:     next_st.tx_clk = st.s2[PIN_RATE1];
      endcase
      if (!sync_mode && !st.ctrl2[RXCLK_BIT]) begin
         // async 1X with bit three clear is a misprogramming; rate 1 wins
         next_st.rx_clk = st.s2[PIN_RATE1];
      end else if (csel == CS_1X) begin
         next_st.rx_clk = st.s2[PIN_RX1X];
      end else begin
         next_st.rx_clk = next_st.tx_clk;
      end

      // transmit buffer empty; hardware set beats a same-cycle load
      if (tx_buf_load) begin
         next_st.tx_empty = 1'b0;
      end
      if (tx_buf_to_shift) begin
         next_st.tx_empty = 1'b1;
      end
      if (!tx_enable) begin
         next_st.tx_empty = 1'b0;
      end

      // modem change flag; a new change in the read cycle survives the read
      if (rd_stat) begin
         next_st.dsc = 1'b0;
      end
      if (modem_set) begin
         next_st.dsc = 1'b1;
      end

      // receive side
      if (rx_buf_read) begin
         next_st.rx_full = 1'b0;
      end
      if (rd_stat && escape_strip_bit) begin
         next_st.b3 = 1'b0;
      end
      next_st.rx_load = 1'b0;
      next_st.rx_drop = 1'b0;
      if (rx_char_done && rx_enable) begin
         next_st.prev_esc = esc_hit;
         if (esc_hit || strip_hit) begin
            next_st.rx_drop = 1'b1;
            if (strip_hit && sync_strip_active()) begin
               next_st.sync_pend = 1'b1;
            end
         end else begin
            next_st.rx_load = 1'b1;
            next_st.rx_full = 1'b1;
            next_st.ovr     = st.rx_full && !rx_buf_read;
            if (escape_strip_bit) begin
               next_st.b3 = st.prev_esc;
            end else begin
               next_st.b3 = rx_parity_check_bit && parity_bad;
            end
            if (sync_mode) begin
               next_st.b4        = syn_hit || st.sync_pend;
               next_st.sync_pend = 1'b0;
            end else begin
               next_st.b4 = !rx_stop_ok;
            end
         end
      end
      if (!rx_enable) begin
         next_st.rx_full   = 1'b0;
         next_st.ovr       = 1'b0;
         next_st.b3        = 1'b0;
         next_st.b4        = 1'b0;
         next_st.prev_esc  = 1'b0;
         next_st.sync_pend = 1'b0;
      end
   end

   function automatic logic sync_strip_active();
      sync_strip_active = sync_mode && st.ctrl2[RXCLK_BIT];
   endfunction

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st       <= '0;
         st.s1    <= PIN_RST;
         st.s2    <= PIN_RST;
         st.cd_q  <= 1'b1;
         st.dsr_q <= 1'b1;
         st.ri_q  <= 1'b1;
         st.dtr_n <= 1'b1;
         st.ctrl2 <= CTRL2_RST;
         st.rdata <= RDATA_RST;
      end else begin
         st <= next_st;
      end
   end

   assign bus_rdata             = st.rdata;
   assign terminal_ready_n      = st.dtr_n;
   assign char_bits             = CHAR_MIN_BITS + {2'b00, ~st.ctrl2[CL_HI:CL_LO]};
   assign sync_mode             = st.ctrl2[MODE_BIT];
   assign odd_parity            = st.ctrl2[ODD_BIT];
   assign tx_parity_on          = sync_mode ? tx_parity_gen_bit : rx_parity_check_bit;
   assign tx_clk_src            = st.tx_clk;
   assign rx_clk_src            = st.rx_clk;
   assign rx_buf_load           = st.rx_load;
   assign rx_char_drop          = st.rx_drop;
   assign tx_buffer_empty_flag  = st.tx_empty;
   assign rx_char_received_flag = st.rx_full;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_char_len_five: assert property (
      (wr_ctrl && bus_wdata[CL_HI:CL_LO] == 2'b11) |=> (char_bits == 4'h5))
      else $error("character length code 11 did not give 5 bits");

   a_mode_sync_set: assert property (
      wr_ctrl |=> (sync_mode == $past(bus_wdata[MODE_BIT])))
      else $error("mode bit not reflected");

   a_parity_sense: assert property (
      wr_ctrl |=> (odd_parity == $past(bus_wdata[ODD_BIT])))
      else $error("parity sense not reflected");

   a_tx_clock_1x: assert property (
      (csel == CS_1X && $stable(st.ctrl2)) |=> (tx_clk_src == $past(st.s2[PIN_TX1X])))
      else $error("1X code did not route transmit timing input");

   a_rx_clock_rate1: assert property (
      (!sync_mode && !st.ctrl2[RXCLK_BIT] && $stable(st.ctrl2))
      |=> (rx_clk_src == $past(st.s2[PIN_RATE1])))
      else $error("async receiver not on rate 1");

   a_strip_no_load: assert property (
      (rx_char_done && rx_enable && strip_hit) |=> (rx_char_drop && !rx_buf_load))
      else $error("stripped character reached the receive buffer");

   a_tx_buffer_empty_flag_on_move: assert property (
      (tx_enable && tx_buf_to_shift) |=> tx_buffer_empty_flag)
      else $error("tx empty not set on buffer move");

   a_rx_off_clear: assert property (
      !rx_enable |=> (!rx_char_received_flag && !st.ovr && !st.b3 && !st.b4))
      else $error("receiver status not cleared while disabled");

   a_overrun_flag: assert property (
      (rx_char_done && rx_enable && !esc_hit && !strip_hit && st.rx_full && !rx_buf_read)
      |=> (st.ovr && rx_buf_load))
      else $error("overrun missed");

   a_frame_error: assert property (
      (rx_char_done && rx_enable && !sync_mode && !rx_stop_ok) |=> st.b4)
      else $error("framing error missed");

   a_modem_cd_read: assert property (
      rd_stat |=> (bus_rdata[ST_CD] == !$past(st.s2[PIN_CD])))
      else $error("carrier bit not inverted input");

   a_change_cleared: assert property (
      (rd_stat && !modem_set) |=> !st.dsc ##1 (st.dsc == $past(modem_set)))
      else $error("modem change flag not cleared by status read");

   a_dtr_pin: assert property (
      terminal_ready_ctrl_bit [*2] |-> !terminal_ready_n)
      else $error("terminal ready pin not inverted");

   a_tx_off_clear: assert property (
      !tx_enable |=> !tx_buffer_empty_flag)
      else $error("tx empty not cleared while transmitter off");

   a_escape_flag: assert property (
      (rx_char_done && rx_enable && escape_strip_bit && !esc_hit && !strip_hit)
      |=> (st.b3 == $past(st.prev_esc)))
      else $error("escape detect not taken from previous character");

   a_parity_error: assert property (
      (rx_char_done && rx_enable && !escape_strip_bit && !strip_hit && rx_parity_check_bit
       && ((^char_m) != odd_parity)) |=> st.b3)
      else $error("parity error missed");

   a_sync_detect: assert property (
      (rx_char_done && rx_enable && sync_mode && !st.ctrl2[RXCLK_BIT] && !esc_hit
       && syn_hit) |=> st.b4)
      else $error("sync match not flagged");

   a_dsr_read_inv: assert property (
      rd_stat |=> (bus_rdata[ST_DSR] == !$past(st.s2[PIN_DSR])))
      else $error("data set ready bit not inverted input");

   a_ring_change: assert property (
      (!terminal_ready_ctrl_bit && st.ri_q && !st.s2[PIN_RI]) |=> st.dsc)
      else $error("ring turn-on did not flag a modem change");

   c_char_load: cover property (rx_char_done && rx_enable ##1 rx_buf_load);
   c_overrun: cover property (rx_buf_load && st.ovr);
   c_sync_strip: cover property (rx_char_drop ##[1:40] rx_buf_load);
   c_modem_change: cover property (st.dsc ##1 rd_stat ##1 !st.dsc);
endmodule

// file: include/ucs_pkg.sv
// constants and types shared by the line format and status register block
// Overview of operation
// - top two bits pick 8/7/6/5-bit characters
// - bit five set means synchronous mode
// - bit four set selects odd parity
// - clock code picks 1X, rates, divided rate4
// - async rx uses rate1 unless bit three
// - sync stripping drops characters, no receive event
// - tx empty set on move, cleared on load
// - received flag set on transfer, cleared on read
// - overrun when unread character gets overwritten
// - escape strip: flag previous escape, no parity
// - otherwise bit three reports parity error
// - async bit four flags missing stop bit
// - sync bit four flags sync match
// - bits five, six show inverted modem inputs
// - modem change flag, cleared by status read
// - rate4 divider gives 32X from faster clocks
// - terminal ready pin is inverted control bit
package ucs_pkg;
   localparam logic       ADDR_CTRL2    = 1'b0;
   localparam logic       ADDR_STATUS   = 1'b1;
   localparam int         CL_HI         = 7;
   localparam int         CL_LO         = 6;
   localparam int         MODE_BIT      = 5;
   localparam int         ODD_BIT       = 4;
   localparam int         RXCLK_BIT     = 3;
   localparam int         CSEL_HI       = 2;
   localparam int         CSEL_LO       = 0;
   localparam int         ST_TX_EMPTY   = 0;
   localparam int         ST_RX_FULL    = 1;
   localparam int         ST_OVR        = 2;
   localparam int         ST_B3         = 3;
   localparam int         ST_B4         = 4;
   localparam int         ST_CD         = 5;
   localparam int         ST_DSR        = 6;
   localparam int         ST_DSC        = 7;
   localparam logic [7:0] CTRL2_RST     = 8'h00;
   localparam logic [7:0] RDATA_RST     = 8'h00;
   localparam logic [7:0] FULL_MASK     = 8'hFF;
   localparam logic [3:0] CHAR_MIN_BITS = 4'h5;
   localparam logic [2:0] DIV_RST       = 3'h0;
   localparam int         PIN_CD        = 0;
   localparam int         PIN_DSR       = 1;
   localparam int         PIN_RI        = 2;
   localparam int         PIN_TX1X      = 3;
   localparam int         PIN_RX1X      = 4;
   localparam int         PIN_RATE1     = 5;
   localparam int         PIN_RATE2     = 6;
   localparam int         PIN_RATE3     = 7;
   localparam int         PIN_RATE4     = 8;
   localparam int         PIN_W         = 9;
   localparam logic [PIN_W-1:0] PIN_RST = 9'h1_FF;

   typedef enum logic [2:0] {
      CS_1X       = 3'h0,
      CS_RATE1    = 3'h1,
      CS_RATE2    = 3'h2,
      CS_RATE3    = 3'h3,
      CS_RATE4    = 3'h4,
      CS_RATE4_D2 = 3'h5,
      CS_RATE4_D4 = 3'h6,
      CS_RATE4_D8 = 3'h7
   } ucs_csel_t;
endpackage

// file: testbench/ucs_modem_model.sv
// modem and clock pin source on the serial side of the status block
module ucs_modem_model (
   input  wire logic sys_clk,
   output logic      cd_n,
   output logic      dsr_n,
   output logic      ri_n,
   output logic      tx_1x_clk,
   output logic      rx_1x_clk,
   output logic      rate1_clk,
   output logic      rate2_clk,
   output logic      rate3_clk,
   output logic      rate4_clk
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] pins = 8'h07;
   logic [1:0] r4_cnt = 2'h0;
   // slow lines move only when asked, idle high for the active-low modem lines
   task automatic set_pins(input logic [7:0] v);
      pins <= v;
   endtask
   // rate four runs at a quarter of the sampling rate, toggling every two cycles, so the dividers have work
   always @(posedge sys_clk) begin
      r4_cnt <= r4_cnt + 2'h1;
   end
   assign {rate3_clk, rate2_clk, rate1_clk, rx_1x_clk, tx_1x_clk, ri_n, dsr_n, cd_n} = pins;
   assign rate4_clk = r4_cnt[1];
endmodule

// file: testbench/ucs_regs_tb_top.sv
// self-checking bench for the format/clock control and status registers
module ucs_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ucs_pkg::*;
   logic       sys_clk, rst_n, bus_sel, bus_rd, bus_wr, bus_addr, terminal_ready_ctrl_bit;
   logic [7:0] bus_wdata, bus_rdata, escape_char, sync_char, rx_char, st;
   logic       rx_enable, tx_enable, rx_parity_check_bit, escape_strip_bit, tx_parity_gen_bit;
   logic       transparent_mode_bit, tx_buf_load, tx_buf_to_shift, rx_char_done, rx_stop_ok;
   logic       rx_buf_read, cd_n, dsr_n, ri_n, tx_1x_clk, rx_1x_clk, rate1_clk, rate2_clk;
   logic       rate3_clk, rate4_clk, terminal_ready_n, sync_mode, odd_parity, tx_parity_on;
   logic       tx_clk_src, rx_clk_src, rx_buf_load, rx_char_drop, pv;
   logic       tx_buffer_empty_flag, rx_char_received_flag;
   logic [3:0] char_bits;
   logic [1:0] ld;
   int         i, n, cycles = 0, err_count = 0, checked = 0;
   logic [7:0] tc [6] = '{8'h08, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h02};
   logic [7:0] tp [6] = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h20};
   logic [1:0] te [6] = '{2'h2, 2'h1, 2'h3, 2'h3, 2'h3, 2'h1};

   ucs_regs dut_u (.sys_clk, .rst_n, .bus_sel, .bus_rd, .bus_wr, .bus_addr, .bus_wdata,
      .bus_rdata, .terminal_ready_ctrl_bit, .rx_enable, .tx_enable, .rx_parity_check_bit,
      .escape_strip_bit, .tx_parity_gen_bit, .transparent_mode_bit, .escape_char, .sync_char,
      .tx_buf_load, .tx_buf_to_shift, .rx_char_done, .rx_char, .rx_stop_ok, .rx_buf_read,
      .cd_n, .dsr_n, .ri_n, .tx_1x_clk, .rx_1x_clk, .rate1_clk, .rate2_clk, .rate3_clk,
      .rate4_clk, .terminal_ready_n, .char_bits, .sync_mode, .odd_parity, .tx_parity_on,
      .tx_clk_src, .rx_clk_src, .rx_buf_load, .rx_char_drop, .tx_buffer_empty_flag,
      .rx_char_received_flag);
   ucs_modem_model modem_u (.sys_clk, .cd_n, .dsr_n, .ri_n, .tx_1x_clk, .rx_1x_clk,
      .rate1_clk, .rate2_clk, .rate3_clk, .rate4_clk);

   always #50 sys_clk = ~sys_clk;

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // generous ceiling, the whole sequence needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         $display("ERROR at %0t: run hung", $time);
         give_verdict();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cb(input logic b, input logic e);
      chk({7'h00, b}, {7'h00, e});
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   // one bus cycle, request held to the taking edge, data sampled once it lands
   task automatic acc(input logic w, input logic a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_sel   <= 1'b1;
      bus_wr    <= w;
      bus_rd    <= !w;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge sys_clk);
      {bus_sel, bus_wr, bus_rd} <= 3'h0;
      #1 st = bus_rdata;
   endtask

   task automatic rdc(input logic a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(st, e);
   endtask

   // 0 load, 1 move to shifter, 2 character done, 3 buffer read
   task automatic ev(input int k, input logic [7:0] ch, input logic stop);
      @(posedge sys_clk);
      tx_buf_load     <= (k == 0);
      tx_buf_to_shift <= (k == 1);
      rx_char_done    <= (k == 2);
      rx_buf_read     <= (k == 3);
      rx_char         <= ch;
      rx_stop_ok      <= stop;
      @(posedge sys_clk);
      {tx_buf_load, tx_buf_to_shift, rx_char_done, rx_buf_read} <= 4'h0;
      #1 ld = {rx_buf_load, rx_char_drop};
   endtask

   // format register is only rewritten with the receiver switched off
   task automatic cfg(input logic [7:0] v);
      @(posedge sys_clk);
      rx_enable <= 1'b0;
      acc(1'b1, ADDR_CTRL2, v);
      @(posedge sys_clk);
      rx_enable <= 1'b1;
   endtask

   initial begin
      {sys_clk, rst_n, bus_sel, bus_rd, bus_wr, bus_addr, bus_wdata} = 14'h0000;
      {terminal_ready_ctrl_bit, rx_enable, tx_enable, rx_parity_check_bit} = 4'h0;
      {escape_strip_bit, tx_parity_gen_bit, transparent_mode_bit} = 3'h0;
      {escape_char, sync_char, rx_char} = 24'h10_1600;
      {tx_buf_load, tx_buf_to_shift, rx_char_done, rx_stop_ok, rx_buf_read} = 5'h00;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdc(ADDR_CTRL2, CTRL2_RST);
      rdc(ADDR_STATUS, 8'h00);
      cb(terminal_ready_n, 1'b1);
      for (i = 0; i < 4; i++) begin
         acc(1'b1, ADDR_CTRL2, {i[1:0], i[0], i[1], 4'h0});
         rdc(ADDR_CTRL2, {i[1:0], i[0], i[1], 4'h0});
         chk({4'h0, char_bits}, 8'(8 - i));
         cb(sync_mode, i[0]);
         cb(odd_parity, i[1]);
      end
      $display("test format done");
      for (i = 0; i < 6; i++) begin
         acc(1'b1, ADDR_CTRL2, tc[i]);
         modem_u.set_pins(8'h07 | tp[i]);
         cyc(6);
         chk({6'h00, tx_clk_src, rx_clk_src}, {6'h00, te[i]});
      end
      modem_u.set_pins(8'h07);
      for (i = 4; i < 8; i++) begin
         acc(1'b1, ADDR_CTRL2, 8'(8 + i));
         cyc(6);
         n = 0;
         pv = tx_clk_src;
         repeat (64) begin
            cyc(1);
            n += (tx_clk_src === 1'b1 && pv === 1'b0);
            pv = tx_clk_src;
         end
         cb(n >= (16 >> (i - 4)) - 1 && n <= (16 >> (i - 4)) + 1, 1'b1);
      end
      $display("test clocks done");
      @(posedge sys_clk);
      tx_enable <= 1'b1;
      ev(1, 8'h00, 1'b1);
      cb(tx_buffer_empty_flag, 1'b1);
      ev(0, 8'h00, 1'b1);
      cb(tx_buffer_empty_flag, 1'b0);
      ev(1, 8'h00, 1'b1);
      @(posedge sys_clk);
      tx_enable <= 1'b0;
      cyc(2);
      cb(tx_buffer_empty_flag, 1'b0);
      $display("test transmit done");
      @(posedge sys_clk);
      rx_parity_check_bit <= 1'b1;
      cfg(8'h08);
      ev(2, 8'h03, 1'b1);
      chk({6'h00, ld}, 8'h02);
      cb(tx_parity_on, 1'b1);
      rdc(ADDR_STATUS, 8'h02);
      ev(2, 8'h01, 1'b0);
      rdc(ADDR_STATUS, 8'h1E);
      ev(3, 8'h00, 1'b1);
      cb(rx_char_received_flag, 1'b0);
      ev(2, 8'h03, 1'b1);
      rdc(ADDR_STATUS, 8'h02);
      cfg(8'hD8);
      ev(2, 8'hE0, 1'b1);
      rdc(ADDR_STATUS, 8'h0A);
      @(posedge sys_clk);
      rx_enable <= 1'b0;
      cyc(2);
      rdc(ADDR_STATUS, 8'h00);
      $display("test receive done");
      @(posedge sys_clk);
      {escape_strip_bit, transparent_mode_bit} <= 2'h3;
      cfg(8'h28);
      cb(tx_parity_on, 1'b0);
      ev(2, 8'h10, 1'b1);
      chk({6'h00, ld}, 8'h01);
      cb(rx_char_received_flag, 1'b0);
      ev(2, 8'h40, 1'b1);
      rdc(ADDR_STATUS, 8'h0A);
      rdc(ADDR_STATUS, 8'h02);
      @(posedge sys_clk);
      {escape_strip_bit, transparent_mode_bit, rx_parity_check_bit} <= 3'h0;
      tx_parity_gen_bit <= 1'b1;
      cfg(8'h28);
      cb(tx_parity_on, 1'b1);
      ev(2, 8'h16, 1'b1);
      chk({6'h00, ld}, 8'h01);
      ev(2, 8'h40, 1'b1);
      rdc(ADDR_STATUS, 8'h12);
      cfg(8'h20);
      ev(2, 8'h16, 1'b1);
      chk({6'h00, ld}, 8'h02);
      rdc(ADDR_STATUS, 8'h12);
      $display("test sync done");
      @(posedge sys_clk);
      rx_enable <= 1'b0;
      terminal_ready_ctrl_bit <= 1'b1;
      cyc(3);
      cb(terminal_ready_n, 1'b0);
      modem_u.set_pins(8'h06);
      cyc(5);
      rdc(ADDR_STATUS, 8'hA0);
      rdc(ADDR_STATUS, 8'h20);
      modem_u.set_pins(8'h04);
      cyc(5);
      rdc(ADDR_STATUS, 8'hE0);
      @(posedge sys_clk);
      terminal_ready_ctrl_bit <= 1'b0;
      cyc(3);
      rdc(ADDR_STATUS, 8'h60);
      modem_u.set_pins(8'h00);
      cyc(5);
      rdc(ADDR_STATUS, 8'hE0);
      modem_u.set_pins(8'h02);
      cyc(5);
      rdc(ADDR_STATUS, 8'h20);
      $display("test modem done");
      give_verdict();
   end
endmodule
